// [core/srpc_defs.svh]
`ifndef SRPC_DEFS_SVH
`define SRPC_DEFS_SVH

// Register offsets on the plain register port
`define SRPC_OFF_CAUSE     4'h0
`define SRPC_OFF_DBG_CTRL  4'h1
`define SRPC_OFF_CTRL      4'h2
`define SRPC_OFF_INT_STAT  4'h3
`define SRPC_OFF_INT_MASK  4'h4
`define SRPC_OFF_STATE     4'h5

// Field positions
`define SRPC_DBG_REQ_BIT   0
`define SRPC_CTRL_FORCE_BIT 0
`define SRPC_INT_PIN_BIT   0
`define SRPC_INT_POR_BIT   1
`define SRPC_INT_BO_BIT    2
`define SRPC_INT_WDT_BIT   3
`define SRPC_INT_DBG_BIT   4

// Reset values
`define SRPC_CAUSE_RST     8'h80
`define SRPC_INT_RST       5'h00
`define SRPC_CTRL_RST      1'b0

// Timing counts in system clock cycles
`define SRPC_PIN_LOW_MIN   4
`define SRPC_PIN_AGREE_CYC (`SRPC_PIN_LOW_MIN - 1)
`define SRPC_QUIET_CYC     3'd4
`define SRPC_POR_HOLD      256
`define SRPC_BO_HOLD       256
`define SRPC_WDT_HOLD      256
`define SRPC_PIN_HOLD      256
`define SRPC_DBG_HOLD      256

`endif

// [core/srpc_pkg.sv]
package srpc_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    SRPC_IDLE     = 2'b00,
    SRPC_HOLD     = 2'b01,
    SRPC_CHECK    = 2'b10,
    SRPC_PIN_WAIT = 2'b11
  } srpc_state_t;

  // Reset source of the sequence in progress
  typedef enum logic [2:0] {
    SRPC_SRC_POR = 3'b000,
    SRPC_SRC_BO  = 3'b001,
    SRPC_SRC_WDT = 3'b010,
    SRPC_SRC_PIN = 3'b011,
    SRPC_SRC_DBG = 3'b100
  } srpc_src_t;

  // Layout of the reset cause register
  typedef struct packed {
    logic       por;
    logic       stop;
    logic       wdt;
    logic       pin_reset_cause_flag;
    logic [2:0] rsvd;
    logic       lvd;
  } srpc_cause_t;

  // One bit per reset source, interrupt layout
  typedef struct packed {
    logic dbg;
    logic wdt;
    logic bo;
    logic por;
    logic pin;
  } srpc_evt_t;

endpackage : srpc_pkg

// [core/srpc_pin_filter.sv]
`timescale 1ns/1ns
`default_nettype none
`include "srpc_defs.svh"

module srpc_pin_filter
  import srpc_pkg::*;
#(
  parameter int AGREE_CYC = `SRPC_PIN_AGREE_CYC
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic pin_i,
  output var  logic pin_low
);

  logic [2:0] sync_r;
  logic [3:0] low_cnt_r;
  logic       agree;

  initial begin
    if (AGREE_CYC < 1 || AGREE_CYC > 15) begin
      $error("srpc_pin_filter: AGREE_CYC out of range");
    end
  end

  // Three stage synchroniser, idle level high
  always_ff @(posedge clock) begin
    if (rst) begin
      sync_r <= 3'h7;
    end else begin
      sync_r <= {sync_r[1:0], pin_i};
    end
  end

  // Only stages two and three are compared
  assign agree = (sync_r[1] == sync_r[2]);

  // Agreed low cycles counted; disagreement keeps the count
  always_ff @(posedge clock) begin
    if (rst) begin
      low_cnt_r <= 4'h0;
      pin_low   <= 1'b0;
    end else if (agree && sync_r[2]) begin
      low_cnt_r <= 4'h0;
      pin_low   <= 1'b0;
    end else if (agree && !sync_r[2]) begin
      if (low_cnt_r != 4'(AGREE_CYC)) begin
        low_cnt_r <= low_cnt_r + 4'h1;
      end
      if (low_cnt_r == 4'(AGREE_CYC - 1)) begin
        pin_low <= 1'b1;
      end
    end
  end

endmodule // srpc_pin_filter
`default_nettype wire

// [core/srpc_top.sv]
// Summary of operation
// - A pin low for four clocks starts reset unless the pin is forced; three do not.
// - System reset stays asserted while the reset pin is held low.
// - Long pin hold exits reset right after the pin is released.
// - A pin-started reset sets the pin reset cause flag.
// - Pin driven open-drain low during the reset hold or when forced.
// - Internal resets also drive the pin to reset board parts.
// - After an internal event the pin stays low for its delay.
// - Debug reset request bit starts a normal system reset.
// - Debug-started reset leaves the debug unit out of reset.
// - Hardware clears the debug reset request during its reset.
// - Completed debug reset sets the power-on cause flag.
// - Reading the cause register clears its cause flags.
// - Pin cause flag cleared by power-on or pin stop recovery.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "srpc_defs.svh"

module srpc_top
  import srpc_pkg::*;
#(
  parameter int CNT_W     = 16,
  parameter int POR_HOLD  = `SRPC_POR_HOLD,
  parameter int BO_HOLD   = `SRPC_BO_HOLD,
  parameter int WDT_HOLD  = `SRPC_WDT_HOLD,
  parameter int PIN_HOLD  = `SRPC_PIN_HOLD,
  parameter int DBG_HOLD  = `SRPC_DBG_HOLD
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       reset_pin_i,
  output wire logic       reset_pin_o,
  output var  logic       reset_pin_oe,
  input  wire logic       por_event,
  input  wire logic       brownout_detect,
  input  wire logic       watchdog_event,
  input  wire logic       smr_pin_event,
  input  wire logic       lvd_level,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  output var  logic       irq,
  output var  logic       sys_reset,
  output var  logic       onchip_debug_unit_reset
);

  localparam int CNT_MAX = (1 << CNT_W) - 1;

  // Refuse delays the counter cannot hold
  initial begin
    if (CNT_W < 2 || CNT_W > 30) begin
      $error("srpc_top: CNT_W out of range");
    end
    if (POR_HOLD < 1 || POR_HOLD > CNT_MAX ||
        BO_HOLD  < 1 || BO_HOLD  > CNT_MAX ||
        WDT_HOLD < 1 || WDT_HOLD > CNT_MAX ||
        PIN_HOLD < 1 || PIN_HOLD > CNT_MAX ||
        DBG_HOLD < 1 || DBG_HOLD > CNT_MAX) begin
      $error("srpc_top: hold delay out of range");
    end
  end

  srpc_state_t      state_r;
  srpc_state_t      state_nxt;
  srpc_src_t        src_r;
  srpc_src_t        src_nxt;
  srpc_src_t        evt_src;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [2:0]       quiet_r;
  logic             pin_low;
  logic             pin_ok;
  logic             int_evt;
  logic             trig;
  logic             done;
  logic             dbg_req_r;
  logic             force_r;
  srpc_cause_t      cause_r;
  srpc_evt_t        int_stat_r;
  srpc_evt_t        int_mask_r;
  srpc_evt_t        done_vec;
  logic             wr_cause;
  logic             rd_cause;
  logic             wr_dbg;
  logic             wr_ctrl;
  logic             wr_istat;
  logic             wr_imask;

  // Pin synchroniser and low-time filter
  srpc_pin_filter #(
    .AGREE_CYC (`SRPC_PIN_AGREE_CYC)
  ) u_pin_filter (
    .clock   (clock),
    .rst     (rst),
    .pin_i   (reset_pin_i),
    .pin_low (pin_low)
  );

  // Open drain: only ever pulls low
  assign reset_pin_o = 1'b0;

  // Register strobes
  assign rd_cause = reg_rd && (reg_addr == `SRPC_OFF_CAUSE);
  assign wr_cause = reg_wr && (reg_addr == `SRPC_OFF_CAUSE);
  assign wr_dbg   = reg_wr && (reg_addr == `SRPC_OFF_DBG_CTRL);
  assign wr_ctrl  = reg_wr && (reg_addr == `SRPC_OFF_CTRL);
  assign wr_istat = reg_wr && (reg_addr == `SRPC_OFF_INT_STAT);
  assign wr_imask = reg_wr && (reg_addr == `SRPC_OFF_INT_MASK);

  // Internal events are levels; holding one keeps reset reloaded
  assign int_evt = por_event || brownout_detect || watchdog_event;

  // Own drive reads back low, so the pin counts only once it has settled
  assign pin_ok = pin_low && !reset_pin_oe && (quiet_r == 3'd0);

  assign trig = int_evt || pin_ok || dbg_req_r;

  // Source priority: power-on, brown-out, watchdog, pin, debugger
  always_comb begin
    if (por_event) begin
      evt_src = SRPC_SRC_POR;
    end else if (brownout_detect) begin
      evt_src = SRPC_SRC_BO;
    end else if (watchdog_event) begin
      evt_src = SRPC_SRC_WDT;
    end else if (pin_ok) begin
      evt_src = SRPC_SRC_PIN;
    end else begin
      evt_src = SRPC_SRC_DBG;
    end
  end

  // Hold delay per source, minus one for the load cycle
  function automatic logic [CNT_W-1:0] hold_of(srpc_src_t s);
    logic [CNT_W-1:0] v;
    v = CNT_W'(POR_HOLD - 1);
    case (s)
      SRPC_SRC_POR: v = CNT_W'(POR_HOLD - 1);
      SRPC_SRC_BO:  v = CNT_W'(BO_HOLD - 1);
      SRPC_SRC_WDT: v = CNT_W'(WDT_HOLD - 1);
      SRPC_SRC_PIN: v = CNT_W'(PIN_HOLD - 1);
      SRPC_SRC_DBG: v = CNT_W'(DBG_HOLD - 1);
      default:      v = CNT_W'(POR_HOLD - 1);
    endcase
    return v;
  endfunction

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    src_nxt   = src_r;
    cnt_nxt   = cnt_r;
    done      = 1'b0;
    case (state_r)
      SRPC_IDLE: begin
        if (trig) begin
          state_nxt = SRPC_HOLD;
          src_nxt   = evt_src;
          cnt_nxt   = hold_of(evt_src);
        end
      end
      SRPC_HOLD: begin
        if (int_evt) begin
          src_nxt = evt_src;
          cnt_nxt = hold_of(evt_src);
        end else if (cnt_r == '0) begin
          state_nxt = SRPC_CHECK;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      SRPC_CHECK: begin
        if (int_evt) begin
          state_nxt = SRPC_HOLD;
          src_nxt   = evt_src;
          cnt_nxt   = hold_of(evt_src);
        end else if (quiet_r == 3'd0) begin
          if (pin_low) begin
            state_nxt = SRPC_PIN_WAIT;
          end else begin
            state_nxt = SRPC_IDLE;
            done      = 1'b1;
          end
        end
      end
      SRPC_PIN_WAIT: begin
        if (int_evt) begin
          state_nxt = SRPC_HOLD;
          src_nxt   = evt_src;
          cnt_nxt   = hold_of(evt_src);
        end else if (!pin_low) begin
          state_nxt = SRPC_IDLE;
          done      = 1'b1;
        end
      end
      default: begin
        state_nxt = SRPC_IDLE;
      end
    endcase
  end

  // Controller restarts as if powered on: drives the pin from rst
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= SRPC_HOLD;
      src_r   <= SRPC_SRC_POR;
      cnt_r   <= CNT_W'(POR_HOLD - 1);
    end else begin
      state_r <= state_nxt;
      src_r   <= src_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Reset outputs, registered from the next state
  always_ff @(posedge clock) begin
    if (rst) begin
      sys_reset               <= 1'b1;
      onchip_debug_unit_reset <= 1'b1;
    end else begin
      sys_reset               <= (state_nxt != SRPC_IDLE);
      onchip_debug_unit_reset <= (state_nxt != SRPC_IDLE) &&
                                 (src_nxt != SRPC_SRC_DBG);
    end
  end

  // Indicator drive; released after the hold so a held pin can be seen
  always_ff @(posedge clock) begin
    if (rst) begin
      reset_pin_oe <= 1'b1;
    end else begin
      reset_pin_oe <= (state_nxt == SRPC_HOLD) || force_r;
    end
  end

  // Settling time after own drive ends, covers the synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      quiet_r <= `SRPC_QUIET_CYC;
    end else if (reset_pin_oe) begin
      quiet_r <= `SRPC_QUIET_CYC;
    end else if (quiet_r != 3'd0) begin
      quiet_r <= quiet_r - 3'd1;
    end
  end

  // Debugger reset request; a new write wins over the hardware clear
  always_ff @(posedge clock) begin
    if (rst) begin
      dbg_req_r <= 1'b0;
    end else if (wr_dbg && reg_wdata[`SRPC_DBG_REQ_BIT]) begin
      dbg_req_r <= 1'b1;
    end else if (state_r != SRPC_IDLE && src_r == SRPC_SRC_DBG) begin
      dbg_req_r <= 1'b0;
    end
  end

  // Control register: force indicator drive
  always_ff @(posedge clock) begin
    if (rst) begin
      force_r <= `SRPC_CTRL_RST;
    end else if (wr_ctrl) begin
      force_r <= reg_wdata[`SRPC_CTRL_FORCE_BIT];
    end
  end

  // One-hot completion by source
  always_comb begin
    done_vec     = '0;
    done_vec.pin = done && (src_r == SRPC_SRC_PIN);
    done_vec.por = done && (src_r == SRPC_SRC_POR);
    done_vec.bo  = done && (src_r == SRPC_SRC_BO);
    done_vec.wdt = done && (src_r == SRPC_SRC_WDT);
    done_vec.dbg = done && (src_r == SRPC_SRC_DBG);
  end

  // Cause flags: read and event clears first, sets last so sets win
  always_ff @(posedge clock) begin
    if (rst) begin
      cause_r <= `SRPC_CAUSE_RST;
    end else begin
      cause_r.lvd  <= lvd_level;
      cause_r.rsvd <= 3'h0;
      if (rd_cause) begin
        cause_r.por                  <= 1'b0;
        cause_r.stop                 <= 1'b0;
        cause_r.wdt                  <= 1'b0;
        cause_r.pin_reset_cause_flag <= 1'b0;
      end
      if (por_event) begin
        cause_r.pin_reset_cause_flag <= 1'b0;
        cause_r.wdt                  <= 1'b0;
        cause_r.stop                 <= 1'b0;
      end
      if (smr_pin_event) begin
        cause_r.pin_reset_cause_flag <= 1'b0;
        cause_r.wdt                  <= 1'b0;
        cause_r.por                  <= 1'b0;
        cause_r.stop                 <= 1'b1;
      end
      if (done_vec.pin) begin
        cause_r.pin_reset_cause_flag <= 1'b1;
      end
      if (done_vec.por || done_vec.dbg) begin
        cause_r.por <= 1'b1;
      end
      if (done_vec.wdt) begin
        cause_r.wdt <= 1'b1;
        cause_r.por <= 1'b0;
      end
    end
  end

  // Interrupt status, write one to clear, completion wins
  always_ff @(posedge clock) begin
    if (rst) begin
      int_stat_r <= `SRPC_INT_RST;
    end else begin
      int_stat_r <= (int_stat_r & ~(wr_istat ? srpc_evt_t'(reg_wdata[4:0])
                                            : srpc_evt_t'(5'h00)))
                    | done_vec;
    end
  end

  // Interrupt mask
  always_ff @(posedge clock) begin
    if (rst) begin
      int_mask_r <= `SRPC_INT_RST;
    end else if (wr_imask) begin
      int_mask_r <= srpc_evt_t'(reg_wdata[4:0]);
    end
  end

  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_r & int_mask_r);
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SRPC_OFF_CAUSE:    reg_rdata <= cause_r;
        `SRPC_OFF_DBG_CTRL: reg_rdata <= {7'h00, dbg_req_r};
        `SRPC_OFF_CTRL:     reg_rdata <= {7'h00, force_r};
        `SRPC_OFF_INT_STAT: reg_rdata <= {3'h0, int_stat_r};
        `SRPC_OFF_INT_MASK: reg_rdata <= {3'h0, int_mask_r};
        `SRPC_OFF_STATE:    reg_rdata <= {3'h0, src_r, state_r};
        default:            reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Writes to the cause register are ignored; it is read only
  logic unused_ok;
  assign unused_ok = wr_cause;

endmodule // srpc_top
`default_nettype wire

// [tb/srpc_checker.sv]
`timescale 1ns/1ns
`default_nettype none
`include "srpc_defs.svh"

module srpc_checker (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       reset_pin_i,
  input wire logic       reset_pin_o,
  input wire logic       reset_pin_oe,
  input wire logic       por_event,
  input wire logic       brownout_detect,
  input wire logic       watchdog_event,
  input wire logic       smr_pin_event,
  input wire logic       lvd_level,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq,
  input wire logic       sys_reset,
  input wire logic       onchip_debug_unit_reset
);
  // One clock domain, so one clocking and one disable for all
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Pin side: open drain, start, hold and release
  a_open_drain: assert property (reset_pin_o == 1'b0)
    else $error("reset pin output not held low");
  a_pin_starts: assert property (
    (!sys_reset && !reset_pin_oe && !reset_pin_i)[*4] |-> ##[0:10] sys_reset)
    else $error("four low pin cycles did not start reset");
  a_low_keeps: assert property (
    (sys_reset && !reset_pin_i)[*8] |=> sys_reset)
    else $error("reset left while pin held low");
  a_release_exit: assert property (
    ($rose(reset_pin_i) && sys_reset && !reset_pin_oe)
      |-> ##[1:10] (!sys_reset || reset_pin_oe))
    else $error("reset not left after pin release");

  // Internal sources drive the indicator for a minimum time
  a_event_drive: assert property (
    (por_event || brownout_detect || watchdog_event) |-> ##[1:2] reset_pin_oe)
    else $error("internal event did not drive the pin");
  a_hold_min: assert property (
    $rose(reset_pin_oe) |-> reset_pin_oe[*7])
    else $error("indicator released too early");

  // Debug request resets all but the debug unit
  a_dbg_start: assert property (
    (reg_wr && reg_addr == `SRPC_OFF_DBG_CTRL
      && reg_wdata[`SRPC_DBG_REQ_BIT] && !sys_reset && !reset_pin_oe)
      |-> ##2 (sys_reset && !onchip_debug_unit_reset))
    else $error("debug request did not start reset");
  a_dbg_unit_kept: assert property (
    onchip_debug_unit_reset |-> sys_reset)
    else $error("debug unit reset without system reset");

  // Second read of the cause register finds the flags gone
  a_read_clears: assert property (
    (reg_rd && reg_addr == `SRPC_OFF_CAUSE && !sys_reset && !smr_pin_event)
      ##1 (!sys_reset && !smr_pin_event)
      ##1 (reg_rd && reg_addr == `SRPC_OFF_CAUSE && !sys_reset
        && !smr_pin_event) |-> ##1 (reg_rdata[7:4] == 4'h0))
    else $error("cause flags survived a read");
endmodule // srpc_checker

bind srpc_top srpc_checker u_chk (
  .clock, .rst, .reset_pin_i, .reset_pin_o, .reset_pin_oe, .por_event,
  .brownout_detect, .watchdog_event, .smr_pin_event, .lvd_level,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
  .sys_reset, .onchip_debug_unit_reset
);
`default_nettype wire

// [tb/srpc_board.sv]
`timescale 1ns/1ns
`default_nettype none

module srpc_board (
  input  wire logic ext_low,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output wire logic pin
);
  // Pull-up on the wire: released means high, any party may pull low
  assign pin = ~((pin_oe & ~pin_o) | ext_low);
endmodule // srpc_board
`default_nettype wire

// [tb/srpc_top_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "srpc_defs.svh"

`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
  end

module srpc_top_tb;
  localparam int HOLD = 8;
  logic       clock;
  logic       rst = 1'b1;
  logic       ext_low = 1'b0;
  logic       pin;
  logic       pin_o;
  logic       pin_oe;
  logic       por_ev = 1'b0;
  logic       bo_ev = 1'b0;
  logic       wd_ev = 1'b0;
  logic       smr_ev = 1'b0;
  logic       lvd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       irq;
  logic       sys_reset;
  logic       dbg_rst;
  int         bad_count = 0;
  int         n_tests = 0;

  // Short holds keep the run brief
  srpc_top #(.POR_HOLD(HOLD), .BO_HOLD(HOLD), .WDT_HOLD(HOLD),
    .PIN_HOLD(HOLD), .DBG_HOLD(HOLD)) dut (
    .clock(clock), .rst(rst), .reset_pin_i(pin), .reset_pin_o(pin_o),
    .reset_pin_oe(pin_oe), .por_event(por_ev), .brownout_detect(bo_ev),
    .watchdog_event(wd_ev), .smr_pin_event(smr_ev), .lvd_level(lvd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .irq(irq), .sys_reset(sys_reset),
    .onchip_debug_unit_reset(dbg_rst));

  // Board side of the reset wire
  srpc_board board (.ext_low(ext_low), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin(pin));

  // 20 MHz system clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask

  // Bounded wait for the system reset level
  task automatic wt(input logic v);
    for (int i = 0; i < 400; i++) begin
      @(posedge clock);
      #1;
      if (sys_reset === v) break;
    end
    `CHK(sys_reset, v)
  endtask

  task automatic pin_pulse(input int n);
    @(posedge clock);
    ext_low <= 1'b1;
    repeat (n) @(posedge clock);
    ext_low <= 1'b0;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole sequence needs under 300 cycles
  initial begin
    #(50 * 5000);
    bad_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    wt(1'b0);
    rd_reg(`SRPC_OFF_CAUSE, `SRPC_CAUSE_RST);
    rd_reg(`SRPC_OFF_CAUSE, 8'h00);
    wr_reg(4'hf, 8'hff);
    rd_reg(4'hf, 8'h00);
    wr_reg(`SRPC_OFF_INT_STAT, 8'h1f);
    // Shortest pulse that must start a reset
    pin_pulse(4);
    wt(1'b1);
    wt(1'b0);
    rd_reg(`SRPC_OFF_CAUSE, 8'h10);
    `CHK(irq, 1'b0)
    // Long hold, then release
    pin_pulse(40);
    #1 `CHK(sys_reset, 1'b1)
    cyc(8);
    #1 `CHK(sys_reset, 1'b0)
    // Each internal source drives the pin for its hold
    wr_reg(`SRPC_OFF_INT_MASK, 8'h08);
    for (int k = 0; k < 3; k++) begin
      @(posedge clock);
      {wd_ev, bo_ev, por_ev} <= 3'b001 << k;
      @(posedge clock);
      {wd_ev, bo_ev, por_ev} <= 3'b000;
      #1 `CHK(pin_oe, 1'b1)
      cyc(HOLD - 1);
      #1 `CHK(pin_oe, 1'b1)
      wt(1'b0);
    end
    rd_reg(`SRPC_OFF_CAUSE, 8'h20);
    `CHK(irq, 1'b1)
    wr_reg(`SRPC_OFF_INT_STAT, 8'h08);
    cyc(2);
    #1 `CHK(irq, 1'b0)
    rd_reg(`SRPC_OFF_INT_STAT, 8'h07);
    rd_reg(`SRPC_OFF_STATE, 8'h08);
    // Stop recovery by pin change drops the pin flag
    pin_pulse(4);
    wt(1'b1);
    wt(1'b0);
    @(posedge clock);
    smr_ev <= 1'b1;
    @(posedge clock);
    smr_ev <= 1'b0;
    rd_reg(`SRPC_OFF_CAUSE, 8'h40);
    // Debugger request
    wr_reg(`SRPC_OFF_DBG_CTRL, 8'h01);
    @(posedge clock);
    #1 `CHK(sys_reset, 1'b1)
    `CHK(dbg_rst, 1'b0)
    rd_reg(`SRPC_OFF_DBG_CTRL, 8'h00);
    wt(1'b0);
    rd_reg(`SRPC_OFF_CAUSE, 8'h80);
    // Indicator forced by the port logic
    wr_reg(`SRPC_OFF_CTRL, 8'h01);
    cyc(2);
    #1 `CHK(pin, 1'b0)
    rd_reg(`SRPC_OFF_CTRL, 8'h01);
    cyc(10);
    wr_reg(`SRPC_OFF_CTRL, 8'h00);
    cyc(2);
    #1 `CHK(pin_oe, 1'b0)
    // Own drive read back after release must not look like a pin reset
    cyc(8);
    #1 `CHK(sys_reset, 1'b0)
    stop_test();
  end
endmodule // srpc_top_tb
`default_nettype wire
